/* File: src/egp_pkg.sv */
// Purpose: shared constants, types and helpers of the event pin port
// Assumes: 20 MHz system clock, APB register access
// Notes:   byte offsets are word aligned
`default_nettype none

package egp_pkg;
    // ==========================================================
    // sizes and timing
    localparam int NUM_SLOTS     = 12;
    localparam int NUM_EV_PINS   = 5;
    localparam int NUM_ELEC      = 5;
    localparam int CLK_HZ        = 20_000_000;
    localparam int PULSE_TIME_MS = 100;
    localparam int PULSE_CYCLES  = CLK_HZ / 1000 * PULSE_TIME_MS;
    localparam int STRAP_WAIT    = 3;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] REG_SLOT0  = 8'h00;
    localparam logic [7:0] REG_PINMUX = 8'h30;
    localparam logic [7:0] REG_POWER  = 8'h34;
    localparam logic [7:0] REG_STATUS = 8'h38;
    localparam logic [7:0] REG_REJECT = 8'h3c;

    // ==========================================================
    // slot config fields
    localparam int CFG_W       = 17;
    localparam int CFG_EN      = 0;
    localparam int CFG_SRC_LO  = 1;
    localparam int CFG_GES_LO  = 3;
    localparam int CFG_TT_LO   = 6;
    localparam int CFG_ELE_LO  = 8;
    localparam int CFG_ACT_LO  = 11;
    localparam int CFG_PIN_LO  = 14;
    localparam logic [CFG_W-1:0] CFG_RESET = 17'h00000;

    // pinmux fields and reset value
    localparam int PMX_PIN1_EV  = 0;
    localparam int PMX_PIN2_EV  = 1;
    localparam int PMX_PIN3_LO  = 2;
    localparam logic [3:0] PMX_RESET = 4'h0;

    // serial slave address base, low bit from strap
    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h42;

    // ==========================================================
    // enumerations
    typedef enum logic [1:0] {
        SRC_GESTURE  = 2'b00,
        SRC_TOUCH    = 2'b01,
        SRC_APPROACH = 2'b10
    } egp_src_t;

    typedef enum logic [2:0] {
        GES_FLICK_WE = 3'b000,
        GES_FLICK_EW = 3'b001,
        GES_FLICK_NS = 3'b010,
        GES_FLICK_SN = 3'b011,
        GES_CIRC_CW  = 3'b100,
        GES_CIRC_CCW = 3'b101,
        GES_WHEEL_CW = 3'b110
    } egp_gesture_t;

    typedef enum logic [1:0] {
        TT_TOUCH = 2'b00,
        TT_TAP   = 2'b01,
        TT_DTAP  = 2'b10
    } egp_touch_t;

    typedef enum logic [2:0] {
        ACT_PERM_HI = 3'b000,
        ACT_PERM_LO = 3'b001,
        ACT_TOGGLE  = 3'b010,
        ACT_PULSE   = 3'b011,
        ACT_HIGH_AC = 3'b100,
        ACT_LOW_AC  = 3'b101
    } egp_action_t;

    typedef enum logic [1:0] {
        PM_PROCESS  = 2'b00,
        PM_SELFWAKE = 2'b01,
        PM_DEEPSLP  = 2'b10
    } egp_mode_t;

    typedef enum logic [1:0] {
        P3_WAKE  = 2'b00,
        P3_SYNC  = 2'b01,
        P3_EVENT = 2'b10
    } egp_pin3_t;

    // ==========================================================
    // legal source and action pairing
    function automatic logic action_legal(input logic [1:0] src, input logic [2:0] ges,
                                          input logic [1:0] tt, input logic [2:0] act);
        logic lvl;
        logic edg;
        lvl = (act == ACT_HIGH_AC) || (act == ACT_LOW_AC);
        edg = (act == ACT_PERM_HI) || (act == ACT_PERM_LO) || (act == ACT_TOGGLE)
              || (act == ACT_PULSE);
        action_legal = 1'b0;
        if (src == SRC_GESTURE) begin
            if (ges == GES_WHEEL_CW) begin
                action_legal = (act == ACT_PULSE);
            end else begin
                action_legal = edg && (ges != 3'h7);
            end
        end else if (src == SRC_TOUCH) begin
            if (tt == TT_TOUCH) begin
                action_legal = lvl || (act == ACT_TOGGLE) || (act == ACT_PULSE);
            end else begin
                action_legal = edg && (tt != 2'h3);
            end
        end else if (src == SRC_APPROACH) begin
            action_legal = lvl;
        end
    endfunction

    // idle pin level of a slot before any event
    function automatic logic idle_level(input logic [2:0] act);
        idle_level = (act == ACT_PERM_LO) || (act == ACT_LOW_AC);
    endfunction
endpackage

`default_nettype wire

/* File: src/egp_slot_if.sv */
// Purpose: carrier between the port top and one event slot
// Assumes: one instance per slot
// Notes:   events are shared copies driven by the top
`default_nettype none

interface egp_slot_if;
    import egp_pkg::*;
    logic [CFG_W-1:0]    cfg;
    logic                cfg_load;
    logic                run;
    logic                ges_pulse;
    logic [2:0]          ges_code;
    logic [NUM_ELEC-1:0] touch_lvl;
    logic [NUM_ELEC-1:0] tap_pulse;
    logic [NUM_ELEC-1:0] dtap_pulse;
    logic                approach_lvl;
    logic                level;
    logic                reject;

    modport ctrl (output cfg, cfg_load, run, ges_pulse, ges_code, touch_lvl, tap_pulse,
                  dtap_pulse, approach_lvl, input level, reject);
    modport slot (input cfg, cfg_load, run, ges_pulse, ges_code, touch_lvl, tap_pulse,
                  dtap_pulse, approach_lvl, output level, reject);
endinterface

`default_nettype wire

/* File: src/egp_slot.sv */
// Purpose: one configurable event output slot
// Assumes: events are synchronous one-cycle pulses or levels
// Notes:   a config load returns the slot to its idle level
`default_nettype none

module egp_slot
    import egp_pkg::*;
#(
    parameter int PULSE_LEN = PULSE_CYCLES
) (
    input  wire logic    pclk,
    input  wire logic    presetn,
    egp_slot_if.slot     sif
);
    localparam int CW = $clog2(PULSE_LEN + 1);
    localparam logic [CW-1:0] PULSE_LOAD = CW'(PULSE_LEN); // full width, counted down to zero

    // ==========================================================
    // config decode
    wire       en    = sif.cfg[CFG_EN];
    wire [1:0] src   = sif.cfg[CFG_SRC_LO +: 2];
    wire [2:0] ges   = sif.cfg[CFG_GES_LO +: 3];
    wire [1:0] tt    = sif.cfg[CFG_TT_LO +: 2];
    wire [2:0] ele   = sif.cfg[CFG_ELE_LO +: 3];
    wire [2:0] act   = sif.cfg[CFG_ACT_LO +: 3];
    wire       legal = action_legal(src, ges, tt, act);
    wire       idle  = idle_level(act);
    wire       go    = en && legal && (sif.run || (src == SRC_APPROACH));
    wire       ele_ok = (ele < 3'(NUM_ELEC));
    wire [2:0] ele_i = ele_ok ? ele : 3'h0;

    logic          level_r;
    logic [CW-1:0] cnt_r;
    logic          cond_prev_r;

    // qualifying condition and trigger pulse
    wire t_lvl = ele_ok && sif.touch_lvl[ele_i];
    wire cond  = (src == SRC_APPROACH) ? sif.approach_lvl : t_lvl;
    wire trig_ges = sif.ges_pulse && (sif.ges_code == ges);
    wire trig_tch = (tt == TT_TOUCH) ? (cond && !cond_prev_r)
                  : (tt == TT_TAP)   ? (ele_ok && sif.tap_pulse[ele_i])
                  : (ele_ok && sif.dtap_pulse[ele_i]);
    wire trig = (src == SRC_GESTURE) ? trig_ges
              : (src == SRC_TOUCH) ? trig_tch : (cond && !cond_prev_r);

    assign sif.level  = level_r;
    assign sif.reject = en && !legal;

    // ==========================================================
    // waveform generator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r     <= 1'b0;
            cnt_r       <= '0;
            cond_prev_r <= 1'b0;
        end else begin
            cond_prev_r <= cond;
            if (sif.cfg_load || !go) begin
                level_r <= idle;
                cnt_r   <= '0;
            end else begin
                unique case (act)
                    ACT_PERM_HI: if (trig) level_r <= 1'b1;
                    ACT_PERM_LO: if (trig) level_r <= 1'b0;
                    ACT_TOGGLE:  if (trig) level_r <= !level_r;
                    ACT_PULSE: begin
                        if (trig) begin
                            level_r <= 1'b1;
                            cnt_r   <= PULSE_LOAD;
                        end else if (cnt_r != '0) begin
                            cnt_r <= cnt_r - CW'(1);
                            if (cnt_r == CW'(1)) level_r <= 1'b0;
                        end
                    end
                    ACT_HIGH_AC: level_r <= cond;
                    ACT_LOW_AC:  level_r <= !cond;
                    default:     level_r <= idle;
                endcase
            end
        end
    end

    // ==========================================================
    // checks
    a_toggle_flip: assert property (@(posedge pclk) disable iff (!presetn)
        go && !sif.cfg_load && act == ACT_TOGGLE && trig |=> level_r != $past(level_r))
        else $error("toggle did not invert");
    a_pulse_width: assert property (@(posedge pclk) disable iff (!presetn)
        go && !sif.cfg_load && act == ACT_PULSE && trig |=> level_r && cnt_r == PULSE_LOAD)
        else $error("pulse did not start");
    a_active_follow: assert property (@(posedge pclk) disable iff (!presetn)
        go && !sif.cfg_load && act == ACT_HIGH_AC |=> level_r == $past(cond))
        else $error("high active level wrong");
    a_reject_idle: assert property (@(posedge pclk) disable iff (!presetn)
        en && !legal |=> level_r == $past(idle))
        else $error("rejected slot moved");
    c_pulse_end: cover property (@(posedge pclk) disable iff (!presetn)
        act == ACT_PULSE && cnt_r == CW'(1) ##1 !level_r);
    c_toggle: cover property (@(posedge pclk) disable iff (!presetn)
        go && act == ACT_TOGGLE && trig);
endmodule // egp_slot

`default_nettype wire

/* File: src/egp_port.sv */
// Purpose: event output pins, pin mux, strap address and wake logic
// Assumes: event inputs come from logic on pclk; pins are asynchronous
// Notes:   one APB wait state on every access
//
// Function
// - five event pins driven by recognition events
// - twelve slots, each routed to one pin
// - several slots may share one pin
// - trigger source: gesture, touch or approach
// - gesture selector picks flick, circle or wheel
// - touch type: touch, tap or double tap
// - electrode selector picks one of five
// - six actions select pin waveform
// - pulse lasts 100 ms then returns
// - illegal source/action pairs are rejected
// - pins work alongside serial bus traffic
// - strap fixes slave address 0x42 or 0x43
// - extended pins multiplexed per pin function
// - wake request lines return device to processing
// - processing mode keeps event outputs active
//
// Design decisions made here: the APB register port and the placing of the registers.
`default_nettype none

module egp_port
    import egp_pkg::*;
#(
    parameter int PULSE_LEN = PULSE_CYCLES
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [7:0]          paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                ges_pulse,
    input  wire logic [2:0]          ges_code,
    input  wire logic [NUM_ELEC-1:0] touch_lvl,
    input  wire logic [NUM_ELEC-1:0] tap_pulse,
    input  wire logic [NUM_ELEC-1:0] dtap_pulse,
    input  wire logic                approach_lvl,
    input  wire logic                sync_out,
    input  wire logic                ts_assert,
    input  wire logic                sda_drive_low,
    input  wire logic                scl_drive_low,
    input  wire logic                addr_strap_pin,
    input  wire logic                ext_pin_1_i,
    input  wire logic                ext_pin_2_i,
    input  wire logic                ext_pin_3_i,
    input  wire logic                ext_pin_4_i,
    input  wire logic                ext_pin_5_i,
    output logic [7:0]               ext_pin_o,
    output logic [7:0]               ext_pin_oe,
    output logic                     sda_in,
    output logic                     scl_in,
    output logic [6:0]               slave_addr,
    output logic                     processing_mode
);
    // ==========================================================
    // pin synchronisers (stage 1 read only by stage 2)
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic [1:0] wake_prev_r;
    wire  [5:0] pins_raw = {addr_strap_pin, ext_pin_5_i, ext_pin_4_i, ext_pin_3_i,
                            ext_pin_2_i, ext_pin_1_i};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r     <= 6'h3f;
            sync2_r     <= 6'h3f;
            wake_prev_r <= 2'h3;
        end else begin
            sync1_r     <= pins_raw;
            sync2_r     <= sync1_r;
            wake_prev_r <= sync2_r[2:1];
        end
    end

    // ==========================================================
    // registers
    logic [CFG_W-1:0] cfg_r [NUM_SLOTS];
    logic [3:0]       pinmux_r;
    egp_mode_t        mode_r;
    logic             pready_r;
    logic [31:0]      prdata_r;
    logic             pslverr_r;
    logic [1:0]       strap_cnt_r;
    logic             strap_done_r;
    logic [6:0]       slave_addr_r;
    logic             aux_strap_r;
    logic [7:0]       pin_o_r;
    logic [7:0]       pin_oe_r;
    logic [NUM_SLOTS-1:0] load_r;
    logic             proc_r;

    // APB decode
    wire       acc      = psel && penable;
    wire       done     = acc && pready_r;
    wire       wr       = done && pwrite;
    wire [5:0] widx     = paddr[7:2];
    wire       is_slot  = (widx < 6'(NUM_SLOTS));
    wire       is_pmx   = (paddr == REG_PINMUX);
    wire       is_pwr   = (paddr == REG_POWER);
    wire       is_stat  = (paddr == REG_STATUS);
    wire       is_rej   = (paddr == REG_REJECT);
    wire       mapped   = (paddr[1:0] == 2'b00)
                          && (is_slot || is_pmx || is_pwr || is_stat || is_rej);
    wire [3:0] sidx     = widx[3:0];

    // wake requests on lines muxed as wake inputs, active low falling edge
    wire wake_a   = !pinmux_r[PMX_PIN2_EV] && wake_prev_r[0] && !sync2_r[1];
    wire wake_b   = (pinmux_r[PMX_PIN3_LO +: 2] == P3_WAKE) && wake_prev_r[1] && !sync2_r[2];
    wire wake_evt = wake_a || wake_b;

    // slots
    logic [NUM_SLOTS-1:0] slot_lvl;
    logic [NUM_SLOTS-1:0] slot_rej;
    logic [NUM_EV_PINS-1:0] ev_level;

    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
            egp_slot_if sif ();
            assign sif.cfg          = cfg_r[g];
            assign sif.cfg_load     = load_r[g];
            assign sif.run          = (mode_r == PM_PROCESS);
            assign sif.ges_pulse    = ges_pulse;
            assign sif.ges_code     = ges_code;
            assign sif.touch_lvl    = touch_lvl;
            assign sif.tap_pulse    = tap_pulse;
            assign sif.dtap_pulse   = dtap_pulse;
            assign sif.approach_lvl = approach_lvl;
            assign slot_lvl[g]      = sif.level;
            assign slot_rej[g]      = sif.reject;
            egp_slot #(.PULSE_LEN(PULSE_LEN)) u_slot (
                .pclk    (pclk),
                .presetn (presetn),
                .sif     (sif)
            );
        end
    endgenerate

    // wired-or of every enabled slot routed to each event pin
    always_comb begin
        ev_level = '0;
        for (int s = 0; s < NUM_SLOTS; s++) begin
            for (int p = 0; p < NUM_EV_PINS; p++) begin
                if (cfg_r[s][CFG_EN] && cfg_r[s][CFG_PIN_LO +: 3] == 3'(p)) begin
                    ev_level[p] = ev_level[p] | slot_lvl[s];
                end
            end
        end
    end

    // read mux
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0;
        if (is_slot) rd_val = {15'h0, cfg_r[sidx]};
        else if (is_pmx) rd_val = {28'h0, pinmux_r};
        else if (is_pwr) rd_val = {30'h0, mode_r};
        else if (is_stat) rd_val = {14'h0, pin_o_r, aux_strap_r, strap_done_r,
                                     processing_mode, slave_addr_r};
        else if (is_rej) rd_val = {20'h0, slot_rej};
    end

    // APB slave, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= acc && !pready_r;
            pslverr_r <= acc && !pready_r && !mapped;
            prdata_r  <= (acc && !pready_r && !pwrite && mapped) ? rd_val : 32'h0;
        end
    end

    // config writes; wake wins over a sleep request in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int s = 0; s < NUM_SLOTS; s++) cfg_r[s] <= CFG_RESET;
            pinmux_r <= PMX_RESET;
            mode_r   <= PM_PROCESS;
            proc_r   <= 1'b1;
            load_r   <= '0;
        end else begin
            load_r <= '0;
            if (wr && mapped && is_slot) begin
                cfg_r[sidx]  <= pwdata[CFG_W-1:0];
                load_r[sidx] <= 1'b1;
            end
            if (wr && mapped && is_pmx) pinmux_r <= pwdata[3:0];
            if (wake_evt) begin
                mode_r <= PM_PROCESS;
                proc_r <= 1'b1;
            end else if (wr && mapped && is_pwr && pwdata[1:0] != 2'b11) begin
                mode_r <= egp_mode_t'(pwdata[1:0]);
                proc_r <= (pwdata[1:0] == 2'b00);
            end
        end
    end

    // strap capture after synchroniser settles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_cnt_r  <= 2'h0;
            strap_done_r <= 1'b0;
            slave_addr_r <= SLAVE_ADDR_BASE;
            aux_strap_r  <= 1'b0;
        end else if (!strap_done_r) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            if (strap_cnt_r == 2'(STRAP_WAIT)) begin
                strap_done_r <= 1'b1;
                slave_addr_r <= {SLAVE_ADDR_BASE[6:1], sync2_r[5]};
                aux_strap_r  <= sync2_r[0];
            end
        end
    end

    // pin multiplexer, registered; runs independent of bus traffic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_o_r  <= 8'h00;
            pin_oe_r <= 8'h00;
        end else begin
            pin_o_r[0]  <= 1'b0;
            pin_oe_r[0] <= ts_assert;
            pin_o_r[1]  <= ev_level[0];
            pin_oe_r[1] <= pinmux_r[PMX_PIN1_EV];
            pin_o_r[2]  <= ev_level[1];
            pin_oe_r[2] <= pinmux_r[PMX_PIN2_EV];
            pin_o_r[3]  <= (pinmux_r[PMX_PIN3_LO +: 2] == P3_SYNC) ? sync_out : ev_level[2];
            pin_oe_r[3] <= (pinmux_r[PMX_PIN3_LO +: 2] != P3_WAKE);
            pin_o_r[4]  <= 1'b0;
            pin_oe_r[4] <= sda_drive_low;
            pin_o_r[5]  <= 1'b0;
            pin_oe_r[5] <= scl_drive_low;
            pin_o_r[6]  <= ev_level[3];
            pin_oe_r[6] <= 1'b1;
            pin_o_r[7]  <= ev_level[4];
            pin_oe_r[7] <= 1'b1;
        end
    end

    // outputs
    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign ext_pin_o       = pin_o_r;
    assign ext_pin_oe      = pin_oe_r;
    assign sda_in          = sync2_r[3];
    assign scl_in          = sync2_r[4];
    assign slave_addr      = slave_addr_r;
    assign processing_mode = proc_r;

    // ==========================================================
    // checks
    a_strap_addr: assert property (@(posedge pclk) disable iff (!presetn)
        !strap_done_r && strap_cnt_r == 2'(STRAP_WAIT) |=>
        slave_addr == {SLAVE_ADDR_BASE[6:1], $past(sync2_r[5])})
        else $error("slave address not from strap");
    a_strap_hold: assert property (@(posedge pclk) disable iff (!presetn)
        strap_done_r |=> $stable(slave_addr))
        else $error("slave address changed after capture");
    a_wake_mode: assert property (@(posedge pclk) disable iff (!presetn)
        wake_evt |=> processing_mode)
        else $error("wake did not enter processing");
    a_power_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        wr && mapped && is_pwr && pwdata[1:0] == 2'b10 && !wake_evt |=> !processing_mode)
        else $error("sleep request ignored");
    a_ts_drive: assert property (@(posedge pclk) disable iff (!presetn)
        ts_assert |=> ext_pin_oe[0] && !ext_pin_o[0])
        else $error("transfer status not driven");
    a_ts_release: assert property (@(posedge pclk) disable iff (!presetn)
        !ts_assert |=> !ext_pin_oe[0])
        else $error("transfer status held");
    a_pin1_strap: assert property (@(posedge pclk) disable iff (!presetn)
        !pinmux_r[PMX_PIN1_EV] |=> !ext_pin_oe[1])
        else $error("strap pin driven");
    a_pin1_event: assert property (@(posedge pclk) disable iff (!presetn)
        pinmux_r[PMX_PIN1_EV] |=> ext_pin_oe[1] && ext_pin_o[1] == $past(ev_level[0]))
        else $error("event pin one wrong");
    a_pin6_event: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> ext_pin_o[6] == $past(ev_level[3]) && ext_pin_oe[6])
        else $error("event pin six wrong");
    a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !pready_r |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
    a_apb_error: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !pready_r && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_apb_rdata: assert property (@(posedge pclk) disable iff (!presetn)
        !(acc && !pready_r) |=> prdata == 32'h0)
        else $error("read data outside answer");
    c_wake: cover property (@(posedge pclk) disable iff (!presetn)
        mode_r == PM_DEEPSLP ##1 wake_evt);
    c_shared_pin: cover property (@(posedge pclk) disable iff (!presetn)
        ev_level[3] && $countones(slot_lvl) > 1);
    c_reject: cover property (@(posedge pclk) disable iff (!presetn) |slot_rej);
endmodule // egp_port

`default_nettype wire

/* File: test/egp_host_model.sv */
// Purpose: host model watching the event pins and driving the wake lines
// Assumes: undriven lines are pulled high, strap tied high
// Notes:   pin levels resolved from the design's enables
`default_nettype none

module egp_host_model (
    input  wire logic       pclk,
    input  wire logic [7:0] ext_pin_o,
    input  wire logic [7:0] ext_pin_oe,
    output logic            addr_strap_pin,
    output logic [5:1]      pin_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:1] host_drv = 5'h1f; // host levels, idle high

    // ==========================================================
    // wire levels: design wins where its enable is high
    assign pin_i = (ext_pin_oe[5:1] & ext_pin_o[5:1]) | (~ext_pin_oe[5:1] & host_drv);
    assign addr_strap_pin = 1'b1;

    // ==========================================================
    // hold wake request a low for n cycles
    task automatic wake_a(input int n);
        @(posedge pclk);
        host_drv[2] <= 1'b0;
        repeat (n) @(posedge pclk);
        host_drv[2] <= 1'b1;
    endtask
endmodule // egp_host_model

`default_nettype wire

/* File: test/egp_port_bench.sv */
// Purpose: self-checking bench of the event pin port
// Assumes: pulse width shortened to 20 cycles
// Notes:   tests are sequences of bus calls with expected values
`default_nettype none

module egp_port_bench
    import egp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PL = 20;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, ges_pulse = 1'b0, approach_lvl = 1'b0, ts_assert = 1'b0;
    logic        sda_drive_low = 1'b0, sda_in, scl_in;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, slverr, addr_strap_pin, processing_mode;
    logic [2:0]  ges_code = 3'h0;
    logic [4:0]  touch_lvl = 5'h00, tap_pulse = 5'h00, dtap_pulse = 5'h00;
    logic [7:0]  ext_pin_o, ext_pin_oe;
    logic [6:0]  slave_addr;
    logic [5:1]  pin_i;
    int          err_total = 0, num_checks = 0, cyc = 0;

    // 20 MHz clock
    always #25 pclk = ~pclk;

    egp_port #(.PULSE_LEN(PL)) i_egp_port (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ges_pulse(ges_pulse), .ges_code(ges_code),
        .touch_lvl(touch_lvl), .tap_pulse(tap_pulse), .dtap_pulse(dtap_pulse),
        .approach_lvl(approach_lvl), .sync_out(1'b0), .ts_assert(ts_assert),
        .sda_drive_low(sda_drive_low), .scl_drive_low(1'b0), .addr_strap_pin(addr_strap_pin),
        .ext_pin_1_i(pin_i[1]), .ext_pin_2_i(pin_i[2]), .ext_pin_3_i(pin_i[3]),
        .ext_pin_4_i(pin_i[4]), .ext_pin_5_i(pin_i[5]), .ext_pin_o(ext_pin_o),
        .ext_pin_oe(ext_pin_oe), .sda_in(sda_in), .scl_in(scl_in), .slave_addr(slave_addr),
        .processing_mode(processing_mode));
    egp_host_model i_egp_host_model (.pclk(pclk), .ext_pin_o(ext_pin_o),
        .ext_pin_oe(ext_pin_oe), .addr_strap_pin(addr_strap_pin), .pin_i(pin_i));

    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic tk(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one bus transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // cut a hang short
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_total++;
            conclude();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        tk(8);
        presetn <= 1'b1;
        tk(6);
        chk(slave_addr, 7'h43);
        // transfer status pull-down and data line loop-back through the host
        ts_assert <= 1'b1;
        sda_drive_low <= 1'b1;
        tk(4);
        chk({ext_pin_oe[0], ext_pin_o[0], sda_in, scl_in}, 4'b1001);
        chk(ext_pin_oe[7:6], 2'b11);
        ts_assert <= 1'b0;
        sda_drive_low <= 1'b0;
        apb(1'b1, REG_PINMUX, 32'h1);
        apb(1'b1, 8'h00, 32'h1801);
        apb(1'b1, 8'h04, 32'h1005);
        apb(1'b1, 8'h08, 32'hd243);
        apb(1'b0, REG_REJECT, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'hd243);
        apb(1'b0, 8'h40, 32'h0);
        chk(slverr, 1'b1);
        // gesture pulse on pin 1
        ges_pulse <= 1'b1;
        ges_code <= 3'h0;
        tk(1);
        ges_pulse <= 1'b0;
        tk(2);
        chk(ext_pin_o[1] & ext_pin_oe[1], 1'b1);
        tk(PL - 1);
        chk(ext_pin_o[1], 1'b1);
        tk(1);
        chk(ext_pin_o[1], 1'b0);
        // taps: wrong electrode, then two toggles on pin 6
        for (int i = 0; i < 3; i++) begin
            tap_pulse <= (i == 0) ? 5'h02 : 5'h04;
            tk(1);
            tap_pulse <= 5'h00;
            tk(3);
            chk(ext_pin_o[6], 1'(i == 1));
        end
        apb(1'b1, REG_POWER, 32'h2);
        tk(2);
        chk(processing_mode, 1'b0);
        i_egp_host_model.wake_a(3);
        tk(5);
        chk(processing_mode, 1'b1);
        conclude();
    end
endmodule // egp_port_bench

`default_nettype wire
